// ===== counter_pkg.sv
// Constants shared by the counter pair, its PLL stage and their interface.
// Assumes a single 10 MHz system clock and a plain strobed register port.
`default_nettype none
package counter_pkg;
   localparam int unsigned NUM_COUNTERS = 2;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned NUM_PINS = 32;
   localparam int unsigned PIN_SEL_W = 5;
   localparam int unsigned DIV_W = 3;
   localparam int unsigned EXT_W = 3;

   // Register indexes on the software port.
   localparam logic [2:0] ADDR_FIRST_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_FIRST_FREQUENCY = 3'h1;
   localparam logic [2:0] ADDR_FIRST_PHASE = 3'h2;
   localparam logic [2:0] ADDR_SECOND_CONTROL = 3'h4;
   localparam logic [2:0] ADDR_SECOND_FREQUENCY = 3'h5;
   localparam logic [2:0] ADDR_SECOND_PHASE = 3'h6;
   localparam logic [2:0] ADDR_COUNTER_STRIDE = 3'h4;
   localparam logic [1:0] SLOT_CONTROL = 2'h0;
   localparam logic [1:0] SLOT_FREQUENCY = 2'h1;
   localparam logic [1:0] SLOT_PHASE = 2'h2;

   // Control register field positions.
   localparam int unsigned MODE_LSB = 26;
   localparam int unsigned MODE_W = 5;
   localparam int unsigned DIV_LSB = 23;
   localparam int unsigned SECOND_PIN_LSB = 9;
   localparam int unsigned FIRST_PIN_LSB = 0;
   localparam int unsigned PHASE_MSB = 31;

   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // PLL stage: the reference is multiplied by 16 and divided by
   // 2**(7 - divider), so the output is bit (TOP_BIT - divider).
   localparam int unsigned PLL_TOP_BIT = 34;

   localparam logic [4:0] MODE_OFF = 5'h00;
   localparam logic [4:0] MODE_PLL_INTERNAL = 5'h01;
   localparam logic [4:0] MODE_PLL_SINGLE = 5'h02;
   localparam logic [4:0] MODE_PLL_DIFF = 5'h03;
   localparam logic [4:0] MODE_NCO_SINGLE = 5'h04;
endpackage
`default_nettype wire

// ===== pll_link_if.sv
// Signals between one counter and its PLL stage.
// Assumes both ends share the system clock.
`default_nettype none
interface pll_link_if;
   logic [31:0] phase;
   logic [2:0] divider;
   logic enable;
   logic clear;
   logic out;
   modport counter (output phase, output divider, output enable,
                    output clear, input out);
   modport pll (input phase, input divider, input enable,
                input clear, output out);
endinterface
`default_nettype wire

// ===== pll_stage.sv
// PLL stage of one counter: multiplies and divides the accumulator's top bit.
// Assumes the counter drives the link from the same clock.
`default_nettype none
module pll_stage (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   pll_link_if.pll link
);
   logic msb_prev_reg;
   logic [counter_pkg::EXT_W-1:0] ext_reg;
   logic [counter_pkg::PLL_TOP_BIT:0] virt;

   ////////////////////////////////////////////////////////////////////////////
   // Counting wraps of the top bit extends the phase, which is what lets the
   // low divider settings run slower than the reference itself.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         msb_prev_reg <= 1'b0;
         ext_reg <= '0;
      end else if (ce) begin
         if (link.clear) begin
            msb_prev_reg <= 1'b0;
            ext_reg <= '0;
         end else if (link.enable) begin
            msb_prev_reg <= link.phase[counter_pkg::PHASE_MSB];
            if (link.phase[counter_pkg::PHASE_MSB] && !msb_prev_reg) begin
               ext_reg <= ext_reg + 3'h1;
            end
         end
      end
   end

   assign virt = {ext_reg, link.phase};

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         link.out <= 1'b0;
      end else if (ce) begin
         if (link.clear || !link.enable) begin
            link.out <= 1'b0;
         end else begin
            link.out <= virt[6'(counter_pkg::PLL_TOP_BIT) -
                             6'(link.divider)];
         end
      end
   end
endmodule
`default_nettype wire

// ===== counter_pair.sv
// Two independent phase-accumulator counters of one processing core.
// Assumes synchronous core start/stop pulses and a strobed register port.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
// Notes on behaviour
// - Two identical counters, each with own control, frequency, phase, pins.
// - Control: mode 30..26, divider 25..23, second pin 14..9, first 5..0.
// - Top bit of each six-bit pin index is ignored.
// - Phase accumulator is readable at any time, writable except in a core start or stop cycle.
// - Accumulate condition true adds frequency into phase, modulo 2**32.
// - Mode zero never accumulates; modes one to four accumulate every cycle.
// - Mode zero is off, mode one runs PLL internally; neither drives pins.
// - Modes two, three, four drive PLL, PLL and inverted PLL, phase top bit.
// - Divider field picks the PLL division, only used in PLL modes.
// - Core start clears all registers of both counters.
// - Core stop halts all counting and clears every register.
module counter_pair (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic core_start,
   input wire logic core_stop,
   input wire logic [counter_pkg::ADDR_W-1:0] addr,
   input wire logic [counter_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [counter_pkg::DATA_W-1:0] rdata,
   output logic [counter_pkg::NUM_PINS-1:0] pin_out,
   output logic [counter_pkg::NUM_PINS-1:0] pin_oe
);
   logic [31:0] control_reg [counter_pkg::NUM_COUNTERS];
   logic [31:0] frequency_reg [counter_pkg::NUM_COUNTERS];
   logic [31:0] phase_reg [counter_pkg::NUM_COUNTERS];
   logic running_reg;
   logic [counter_pkg::NUM_COUNTERS-1:0] pll_out;
   logic [counter_pkg::NUM_PINS-1:0] pin_out_next;
   logic [counter_pkg::NUM_PINS-1:0] pin_oe_next;
   logic [31:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] mode_of(input logic [31:0] ctl);
      mode_of = ctl[counter_pkg::MODE_LSB +: counter_pkg::MODE_W];
   endfunction

   function automatic logic [2:0] divider_of(input logic [31:0] ctl);
      divider_of = ctl[counter_pkg::DIV_LSB +: counter_pkg::DIV_W];
   endfunction

   // Only five bits select a pin, so the reserved top bit never matters.
   function automatic logic [4:0] first_pin_of(input logic [31:0] ctl);
      first_pin_of = ctl[counter_pkg::FIRST_PIN_LSB +:
                         counter_pkg::PIN_SEL_W];
   endfunction

   function automatic logic [4:0] second_pin_of(input logic [31:0] ctl);
      second_pin_of = ctl[counter_pkg::SECOND_PIN_LSB +:
                          counter_pkg::PIN_SEL_W];
   endfunction

   function automatic logic accumulates(input logic [31:0] ctl);
      logic [4:0] m;
      m = mode_of(ctl);
      accumulates = (m != counter_pkg::MODE_OFF) &&
                    (m <= counter_pkg::MODE_NCO_SINGLE);
   endfunction

   function automatic logic is_pll_mode(input logic [31:0] ctl);
      logic [4:0] m;
      m = mode_of(ctl);
      is_pll_mode = (m == counter_pkg::MODE_PLL_INTERNAL) ||
                    (m == counter_pkg::MODE_PLL_SINGLE) ||
                    (m == counter_pkg::MODE_PLL_DIFF);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // A stopped core keeps its registers writable but nothing counts until
   // the next start.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         running_reg <= 1'b0;
      end else if (ce) begin
         if (core_stop) begin
            running_reg <= 1'b0;
         end else if (core_start) begin
            running_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file. A software write to the phase wins over accumulation in
   // the same cycle; only a core start or stop in that cycle discards it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < counter_pkg::NUM_COUNTERS; i++) begin
            control_reg[i] <= counter_pkg::REG_RESET;
            frequency_reg[i] <= counter_pkg::REG_RESET;
            phase_reg[i] <= counter_pkg::REG_RESET;
         end
      end else if (ce) begin
         for (int i = 0; i < counter_pkg::NUM_COUNTERS; i++) begin
            if (core_start || core_stop) begin
               control_reg[i] <= counter_pkg::REG_RESET;
               frequency_reg[i] <= counter_pkg::REG_RESET;
               phase_reg[i] <= counter_pkg::REG_RESET;
            end else begin
               if (wr && addr == 3'(i * counter_pkg::ADDR_COUNTER_STRIDE
                                    + counter_pkg::SLOT_CONTROL)) begin
                  control_reg[i] <= wdata;
               end
               if (wr && addr == 3'(i * counter_pkg::ADDR_COUNTER_STRIDE
                                    + counter_pkg::SLOT_FREQUENCY)) begin
                  frequency_reg[i] <= wdata;
               end
               if (wr && addr == 3'(i * counter_pkg::ADDR_COUNTER_STRIDE
                                    + counter_pkg::SLOT_PHASE)) begin
                  phase_reg[i] <= wdata;
               end else if (running_reg && accumulates(control_reg[i])) begin
                  phase_reg[i] <= phase_reg[i] + frequency_reg[i];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One PLL stage per counter; the stages share nothing.
   for (genvar g = 0; g < counter_pkg::NUM_COUNTERS; g++) begin : g_pll
      pll_link_if link ();
      assign link.phase = phase_reg[g];
      assign link.divider = divider_of(control_reg[g]);
      assign link.enable = running_reg && is_pll_mode(control_reg[g]);
      assign link.clear = core_start || core_stop;
      assign pll_out[g] = link.out;
      pll_stage u_pll (
         .ref_clk(ref_clk),
         .rst(rst),
         .ce(ce),
         .link(link.pll)
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive. When both counters pick the same pin their levels are ORed,
   // which is the safe merge for an unshared output bus.
   always_comb begin
      logic [4:0] pa;
      logic [4:0] pb;
      logic [4:0] m;
      pa = '0;
      pb = '0;
      m = '0;
      pin_out_next = '0;
      pin_oe_next = '0;
      for (int i = 0; i < counter_pkg::NUM_COUNTERS; i++) begin
         pa = first_pin_of(control_reg[i]);
         pb = second_pin_of(control_reg[i]);
         m = mode_of(control_reg[i]);
         if (running_reg) begin
            if (m == counter_pkg::MODE_PLL_SINGLE ||
                m == counter_pkg::MODE_PLL_DIFF) begin
               pin_oe_next[pa] = 1'b1;
               pin_out_next[pa] = pin_out_next[pa] | pll_out[i];
            end
            if (m == counter_pkg::MODE_PLL_DIFF) begin
               pin_oe_next[pb] = 1'b1;
               pin_out_next[pb] = pin_out_next[pb] | !pll_out[i];
            end
            if (m == counter_pkg::MODE_NCO_SINGLE) begin
               pin_oe_next[pa] = 1'b1;
               pin_out_next[pa] = pin_out_next[pa] |
                                  phase_reg[i][counter_pkg::PHASE_MSB];
            end
            // Modes off and PLL internal leave both pins undriven.
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else if (ce) begin
         pin_out <= pin_out_next;
         pin_oe <= pin_oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses read zero.
   always_comb begin
      unique case (addr)
         counter_pkg::ADDR_FIRST_CONTROL: rdata_next = control_reg[0];
         counter_pkg::ADDR_FIRST_FREQUENCY: rdata_next = frequency_reg[0];
         counter_pkg::ADDR_FIRST_PHASE: rdata_next = phase_reg[0];
         counter_pkg::ADDR_SECOND_CONTROL: rdata_next = control_reg[1];
         counter_pkg::ADDR_SECOND_FREQUENCY: rdata_next = frequency_reg[1];
         counter_pkg::ADDR_SECOND_PHASE: rdata_next = phase_reg[1];
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= rd ? rdata_next : '0;
      end
   end
endmodule
`default_nettype wire

// ===== counter_pair_sva.sv
// Port-level checker for the counter pair, bound to its top module.
// Assumes one clock and an active-high asynchronous reset.
`default_nettype none
module counter_pair_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic core_start,
   input wire logic core_stop,
   input wire logic [2:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe
);
   logic run_reg;
   logic [1:0] idle_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) run_reg <= 1'b0;
      else if (ce && (core_start || core_stop)) run_reg <= !core_stop;
   end
   // Saturates at two, the pin lag after the core last ran.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) idle_reg <= 2'h0;
      else if (run_reg || core_start) idle_reg <= 2'h0;
      else if (ce && idle_reg != 2'h2) idle_reg <= idle_reg + 2'h1;
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_start;
      ce && core_start ##1 ce;
   endsequence
   sequence s_stop;
      ce && core_stop ##1 ce;
   endsequence
   property p_rdata_idle;
      $past(ce) && !$past(rd) |-> rdata == 32'h0;
   endproperty
   property p_unmapped;
      ce && rd && addr[1:0] == 2'h3 |=> rdata == 32'h0;
   endproperty
   property p_start_read;
      s_start ##0 rd |=> rdata == 32'h0;
   endproperty
   property p_stop_read;
      s_stop ##0 rd |=> rdata == 32'h0;
   endproperty
   property p_start_pins;
      s_start |=> pin_oe == 32'h0;
   endproperty
   property p_stop_pins;
      s_stop |=> (pin_oe | pin_out) == 32'h0;
   endproperty
   property p_out_oe;
      (pin_out & ~pin_oe) == 32'h0;
   endproperty
   property p_idle_pins;
      idle_reg == 2'h2 |-> pin_oe == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_start_read: assert property (p_start_read)
      else $error("register not cleared by start");
   a_stop_read: assert property (p_stop_read)
      else $error("register not cleared by stop");
   a_start_pins: assert property (p_start_pins)
      else $error("pin driven after start");
   a_stop_pins: assert property (p_stop_pins)
      else $error("pin driven after stop");
   a_out_oe: assert property (p_out_oe)
      else $error("pin level high while not driven");
   a_idle_pins: assert property (p_idle_pins)
      else $error("pin driven while core stopped");
endmodule
bind counter_pair counter_pair_sva chk (.ref_clk(ref_clk), .rst(rst),
   .ce(ce), .core_start(core_start), .core_stop(core_stop), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out),
   .pin_oe(pin_oe));
`default_nettype wire

// ===== gpio_pads.sv
// Model of the pads that the counter outputs drive.
// Assumes a pull-down on every pad, so an undriven pad reads low.
`default_nettype none
module gpio_pads (
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   output logic [31:0] pad
);
   assign pad = pin_out & pin_oe;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the counter pair and its pads.
// Assumes reads answer one cycle after the strobe, as the port promises.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst, ce, core_start, core_stop, wr, rd, rd_d;
   logic [2:0] addr, base;
   logic [31:0] wdata, rdata, pin_out, pin_oe, pad, seed, p, f, n;
   logic [31:0] exp_q[$];
   int failures, total_checks, cycles;
   counter_pair uut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .core_start(core_start), .core_stop(core_stop), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out),
      .pin_oe(pin_oe));
   gpio_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Strobes stay up until the next call, so calls can run back to back.
   task automatic bus(input logic w, input logic [2:0] a,
         input logic [31:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w) exp_q.push_back(d);
      @(posedge ref_clk);
   endtask
   task automatic idle(input int k);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic core(input logic s);
      core_start <= s;
      core_stop <= !s;
      @(posedge ref_clk);
      core_start <= 1'b0;
      core_stop <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) rd_d <= rd && ce;
   always @(negedge ref_clk) begin
      if (rd_d) check(rdata, exp_q.pop_front());
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      core_start = 1'b0;
      core_stop = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 32'h0;
      seed = 32'h5b;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      core(1'b1);
      for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 32'h0);
      idle(1);
      $display("test start values done");
      // Mode five shows that codes past the list never count.
      for (int m = 0; m < 6; m++) begin
         seed = xs(seed);
         p = seed;
         seed = xs(seed);
         f = seed;
         base = (m % 2) ? 3'h4 : 3'h0;
         bus(1'b1, base + 3'h1, f);
         bus(1'b1, base + 3'h2, p);
         bus(1'b1, base, {1'b0, m[4:0], 26'h0});
         idle(m + 2);
         bus(1'b1, base, 32'h0);
         n = (m > 0 && m < 5) ? m + 3 : 0;
         bus(1'b0, base + 3'h2, p + f * n);
         bus(1'b0, base + 3'h1, f);
      end
      idle(1);
      $display("test accumulate done");
      // Five cycles with the clock enable low must not count.
      seed = xs(seed);
      f = seed;
      bus(1'b1, 3'h1, f);
      bus(1'b1, 3'h2, p);
      bus(1'b1, 3'h0, {1'b0, 5'h04, 26'h0});
      ce <= 1'b0;
      idle(5);
      ce <= 1'b1;
      idle(1);
      bus(1'b1, 3'h0, 32'h0);
      bus(1'b0, 3'h2, p + f * 2);
      idle(1);
      $display("test freeze done");
      // Pin fields carry their ignored top bit set.
      for (int m = 0; m < 5; m++) begin
         bus(1'b1, 3'h6, 32'h8000_0000);
         bus(1'b1, 3'h5, 32'h0);
         bus(1'b1, 3'h4, {1'b0, m[4:0], 3'h3, 8'h0, 6'h23, 3'h0, 6'h22});
         idle(3);
         #1;
         check(pin_oe, m == 3 ? 32'hc : (m > 1 ? 32'h4 : 32'h0));
         check(pad, m > 1 ? 32'h4 : 32'h0);
      end
      $display("test pins done");
      core(1'b0);
      for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 32'h0);
      idle(2);
      #1;
      check(pin_oe, 32'h0);
      check(pin_out, 32'h0);
      $display("test stop done");
      stop_test();
   end
endmodule
`default_nettype wire
